/* File: tsr_pkg.sv */
// shared constants and types for the touch status and reset register bank
`default_nettype none
package tsr_pkg;
    // register offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_PRESS = 8'h01;
    localparam logic [7:0] OFS_RESULT_CH0_LOW = 8'h02;
    localparam logic [7:0] OFS_RESULT_CH3_HIGH = 8'h09;
    localparam logic [7:0] OFS_RESET = 8'h0A;
    // status bit positions
    localparam int STAT_OUT_BIT = 7;
    localparam int STAT_READY_BIT = 6;
    localparam int STAT_WRRDY_BIT = 5;
    localparam int STAT_FULLSCALE_BIT = 4;
    localparam int STAT_FSMWD_BIT = 3;
    localparam int STAT_OSCFAIL_BIT = 2;
    localparam int STAT_TIMEOUT_BIT = 1;
    localparam int STAT_REGFLAG_BIT = 0;
    // reset register fields
    localparam int RST_FULL_BIT = 4;
    localparam int RST_HOLD_BIT = 0;
    localparam logic [7:0] RESET_REG_DEFAULT = 8'h00;
    // result format
    localparam int RESULT_W = 12;
    localparam int MAX_CH = 4;
    localparam logic [11:0] FULL_SCALE_POS = 12'h7FF;
    localparam logic [11:0] FULL_SCALE_NEG = 12'h800;
    // timing
    localparam longint unsigned CLK_HZ = 64'd50_000_000;
    localparam longint unsigned BUTTON_TIMEOUT_S = 64'd50;
    localparam longint unsigned BUTTON_TIMEOUT_CYC = BUTTON_TIMEOUT_S * CLK_HZ;
    localparam int READY_DELAY_CYC = 1000;
    // bus target address, value arbitrary
    localparam logic [6:0] TARGET_ADDR = 7'h2A;

    // results and press states from the scan engine
    typedef struct packed {
        logic [MAX_CH-1:0] press;
        logic [MAX_CH-1:0][RESULT_W-1:0] result;
        logic sampleValid;
    } tsr_scan_t;

    // fault pulses from the scan engine
    typedef struct packed {
        logic fsmWatchdog;
        logic oscStartFail;
        logic regChange;
    } tsr_fault_t;
endpackage
`default_nettype wire

/* File: tsr_regs.sv */
// status, press, result and reset registers behind a two-wire serial target
`timescale 1ns/1ps
`default_nettype none

module tsr_regs #(
    parameter int CHANNELS = tsr_pkg::MAX_CH,
    parameter longint unsigned TIMEOUT_CYCLES = tsr_pkg::BUTTON_TIMEOUT_CYC,
    parameter int READY_CYCLES = tsr_pkg::READY_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // scan engine side
    input wire tsr_pkg::tsr_scan_t scan,
    input wire tsr_pkg::tsr_fault_t fault,
    output logic convEnable,
    output logic engineReset,
    output logic chipReady
);
    import tsr_pkg::*;

    initial begin
        if (CHANNELS != 2 && CHANNELS != 4) $error("CHANNELS must be 2 or 4");
        if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 64'hFFFF_FFFF) $error("bad TIMEOUT_CYCLES");
        if (READY_CYCLES < 1 || READY_CYCLES > 65535) $error("bad READY_CYCLES");
    end

    typedef enum logic [8:0] {
        S_IDLE = 9'b000000001,
        S_ADDR = 9'b000000010,
        S_ACKA = 9'b000000100,
        S_PTR = 9'b000001000,
        S_ACKP = 9'b000010000,
        S_WDATA = 9'b000100000,
        S_ACKW = 9'b001000000,
        S_RDATA = 9'b010000000,
        S_MACK = 9'b100000000
    } tsr_state_t;

    // ---------------- pin synchronisers ----------------
    logic sclMeta_q, sclSync_q, sclOld_q;
    logic sdaMeta_q, sdaSync_q, sdaOld_q;
    always_ff @(posedge clk) begin
        sclMeta_q <= sclIn;
        sclSync_q <= sclMeta_q;
        sclOld_q <= sclSync_q;
        sdaMeta_q <= sdaIn;
        sdaSync_q <= sdaMeta_q;
        sdaOld_q <= sdaSync_q;
    end
    logic sclRise, sclFall, startCond, stopCond;
    assign sclRise = sclSync_q & ~sclOld_q;
    assign sclFall = ~sclSync_q & sclOld_q;
    assign startCond = sclSync_q & sclOld_q & sdaOld_q & ~sdaSync_q;
    assign stopCond = sclSync_q & sclOld_q & ~sdaOld_q & sdaSync_q;

    // ---------------- serial target ----------------
    tsr_state_t state_q, state_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d, tx_q, tx_d, ptr_q, ptr_d;
    logic rnw_q, rnw_d, drvLow_q, drvLow_d, mAck_q, mAck_d;
    logic rdStrobe, wrStrobe;
    logic [7:0] rdData;

    always_comb begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        rnw_d = rnw_q;
        drvLow_d = drvLow_q;
        mAck_d = mAck_q;
        rdStrobe = 1'b0;
        wrStrobe = 1'b0;
        if (startCond) begin
            state_d = S_ADDR;
            bitCnt_d = 4'h0;
            drvLow_d = 1'b0;
        end else if (stopCond) begin
            state_d = S_IDLE;
            drvLow_d = 1'b0;
        end else if (sclRise) begin
            if (state_q == S_MACK) begin
                mAck_d = ~sdaSync_q;
            end else if (state_q == S_ADDR || state_q == S_PTR || state_q == S_WDATA
                         || state_q == S_RDATA) begin
                shift_d = {shift_q[6:0], sdaSync_q};
                bitCnt_d = bitCnt_q + 4'h1;
            end
        end else if (sclFall) begin
            case (state_q)
                S_ADDR: begin
                    if (bitCnt_q == 4'h8) begin
                        if (shift_q[7:1] == TARGET_ADDR) begin
                            rnw_d = shift_q[0];
                            drvLow_d = 1'b1;
                            state_d = S_ACKA;
                        end else begin
                            state_d = S_IDLE;
                        end
                    end
                end
                S_ACKA, S_MACK: begin
                    bitCnt_d = 4'h0;
                    if (state_q == S_MACK && !mAck_q) begin
                        drvLow_d = 1'b0;
                        state_d = S_IDLE;
                    end else if (rnw_q) begin
                        rdStrobe = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                        drvLow_d = ~rdData[7];
                        tx_d = {rdData[6:0], 1'b0};
                        state_d = S_RDATA;
                    end else begin
                        drvLow_d = 1'b0;
                        state_d = S_PTR;
                    end
                end
                S_PTR, S_WDATA: begin
                    if (bitCnt_q == 4'h8) begin
                        drvLow_d = 1'b1;
                        if (state_q == S_PTR) begin
                            ptr_d = shift_q;
                            state_d = S_ACKP;
                        end else begin
                            wrStrobe = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                            state_d = S_ACKW;
                        end
                    end
                end
                S_ACKP, S_ACKW: begin
                    drvLow_d = 1'b0;
                    bitCnt_d = 4'h0;
                    state_d = S_WDATA;
                end
                S_RDATA: begin
                    if (bitCnt_q == 4'h8) begin
                        drvLow_d = 1'b0;
                        state_d = S_MACK;
                    end else begin
                        drvLow_d = ~tx_q[7];
                        tx_d = {tx_q[6:0], 1'b0};
                    end
                end
                default: begin
                    drvLow_d = 1'b0;
                    state_d = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= S_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rnw_q <= 1'b0;
            drvLow_q <= 1'b0;
            mAck_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            rnw_q <= rnw_d;
            drvLow_q <= drvLow_d;
            mAck_q <= mAck_d;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOeN = ~drvLow_q;

    // ---------------- register bank ----------------
    localparam logic [MAX_CH-1:0] CH_MASK = (CHANNELS == 4) ? 4'hF : 4'h3;
    localparam logic [15:0] READY_LOAD = 16'(READY_CYCLES);
    localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYCLES - 1);

    logic outStat_q, outStat_d, fullScale_q, fullScale_d, fsmWd_q, fsmWd_d;
    logic oscFail_q, oscFail_d, timeout_q, timeout_d, regFlag_q, regFlag_d;
    logic ready_q, ready_d, hold_q, hold_d, halt_q, halt_d, softRst_q, softRst_d;
    logic [15:0] readyCnt_q, readyCnt_d;
    logic [MAX_CH-1:0] livePress_q, livePress_d, snapPress_q, snapPress_d;
    logic [MAX_CH-1:0][RESULT_W-1:0] liveData_q, liveData_d, snapData_q, snapData_d;
    logic [MAX_CH-1:0][31:0] tmoCnt_q, tmoCnt_d;
    logic [7:0] statusView;
    logic statusRead, sampleTake, fsHit, tmoHit, writeReady;

    assign writeReady = ready_q;
    assign statusView = {outStat_q, ready_q, writeReady, fullScale_q,
                         fsmWd_q, oscFail_q, timeout_q, regFlag_q};
    assign statusRead = rdStrobe && ptr_q == OFS_STATUS;
    assign convEnable = ready_q & ~hold_q & ~halt_q;
    assign sampleTake = scan.sampleValid & convEnable;
    assign engineReset = softRst_q;
    assign chipReady = ready_q;

    always_comb begin
        rdData = 8'h00;
        if (ptr_q == OFS_STATUS) begin
            rdData = statusView;
        end else if (ptr_q == OFS_PRESS) begin
            rdData = {4'h0, snapPress_q & CH_MASK};
        end else if (ptr_q == OFS_RESET) begin
            rdData = {7'h00, hold_q};
        end else if (ptr_q >= OFS_RESULT_CH0_LOW && ptr_q <= OFS_RESULT_CH3_HIGH) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (ptr_q == OFS_RESULT_CH0_LOW + 8'(2 * i)) begin
                    rdData = snapData_q[i][7:0];
                end
                if (ptr_q == OFS_RESULT_CH0_LOW + 8'(2 * i + 1)) begin
                    rdData = {4'h0, snapData_q[i][11:8]};
                end
            end
        end
    end

    always_comb begin
        fsHit = 1'b0;
        tmoHit = 1'b0;
        tmoCnt_d = tmoCnt_q;
        livePress_d = livePress_q;
        liveData_d = liveData_q;
        if (sampleTake) begin
            livePress_d = scan.press & CH_MASK;
            liveData_d = scan.result;
            for (int i = 0; i < CHANNELS; i++) begin
                if (scan.result[i] == FULL_SCALE_POS || scan.result[i] == FULL_SCALE_NEG) begin
                    fsHit = 1'b1;
                end
            end
        end
        for (int i = 0; i < MAX_CH; i++) begin
            if (!livePress_q[i]) begin
                tmoCnt_d[i] = 32'h0;
            end else if (tmoCnt_q[i] != TMO_LAST + 32'h1) begin
                tmoCnt_d[i] = tmoCnt_q[i] + 32'h1;
                if (tmoCnt_q[i] == TMO_LAST) begin
                    tmoHit = 1'b1;
                end
            end
        end
    end

    always_comb begin
        outStat_d = (outStat_q & ~statusRead) | (|livePress_q);
        fullScale_d = (fullScale_q & ~statusRead) | fsHit;
        fsmWd_d = (fsmWd_q & ~statusRead) | fault.fsmWatchdog;
        oscFail_d = (oscFail_q & ~statusRead) | fault.oscStartFail;
        timeout_d = (timeout_q & ~statusRead) | tmoHit;
        regFlag_d = (regFlag_q & ~statusRead) | fault.regChange;
        halt_d = halt_q | fault.fsmWatchdog;
        hold_d = hold_q;
        softRst_d = 1'b0;
        ready_d = ready_q;
        readyCnt_d = readyCnt_q;
        snapPress_d = statusRead ? livePress_q : snapPress_q;
        snapData_d = statusRead ? liveData_q : snapData_q;
        if (!ready_q) begin
            if (readyCnt_q <= 16'h1) begin
                ready_d = 1'b1;
            end
            readyCnt_d = readyCnt_q - 16'h1;
        end
        if (wrStrobe && writeReady && ptr_q == OFS_RESET) begin
            hold_d = shift_q[RST_HOLD_BIT];
            if (shift_q[RST_FULL_BIT]) begin
                softRst_d = 1'b1;
                ready_d = 1'b0;
                readyCnt_d = READY_LOAD;
                hold_d = RESET_REG_DEFAULT[RST_HOLD_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset || softRst_q) begin
            outStat_q <= 1'b0;
            fullScale_q <= 1'b0;
            fsmWd_q <= 1'b0;
            oscFail_q <= 1'b0;
            timeout_q <= 1'b0;
            regFlag_q <= 1'b0;
            halt_q <= 1'b0;
            hold_q <= 1'b0;
            livePress_q <= '0;
            snapPress_q <= '0;
            liveData_q <= '0;
            snapData_q <= '0;
            tmoCnt_q <= '0;
        end else begin
            outStat_q <= outStat_d;
            fullScale_q <= fullScale_d;
            fsmWd_q <= fsmWd_d;
            oscFail_q <= oscFail_d;
            timeout_q <= timeout_d;
            regFlag_q <= regFlag_d;
            halt_q <= halt_d;
            hold_q <= hold_d;
            livePress_q <= livePress_d;
            snapPress_q <= snapPress_d;
            liveData_q <= liveData_d;
            snapData_q <= snapData_d;
            tmoCnt_q <= tmoCnt_d;
        end
    end

    // ready and its counter survive the soft reset so the count can run
    always_ff @(posedge clk) begin
        if (reset) begin
            ready_q <= 1'b1;
            readyCnt_q <= 16'h0;
            softRst_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
            readyCnt_q <= readyCnt_d;
            softRst_q <= softRst_d;
        end
    end
endmodule
`default_nettype wire

/* File: tsr_regs_chk.sv */
// concurrent checks on the touch status register bank ports
`timescale 1ns/1ps
`default_nettype none
module tsr_regs_chk
    import tsr_pkg::*;
#(
    parameter int READY_CYCLES = READY_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    // scan engine side
    input wire tsr_pkg::tsr_scan_t scan,
    input wire tsr_pkg::tsr_fault_t fault,
    input wire logic convEnable,
    input wire logic engineReset,
    input wire logic chipReady
);
    logic [15:0] lowCnt_q;
    logic [15:0] lowCnt_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // counts the not-ready span; 16 bits cover every READY_CYCLES the bank accepts
    always_comb begin
        lowCnt_d = chipReady ? 16'h0000 : lowCnt_q + 16'h0001;
    end
    always_ff @(posedge clk) begin
        lowCnt_q <= reset ? 16'h0000 : lowCnt_d;
    end
    chk_reset_defaults: assert property ($fell(reset) |-> sdaOeN && convEnable && chipReady && !engineReset)
        else $error("port defaults wrong after reset");
    chk_engine_pulse: assert property (engineReset |=> !engineReset)
        else $error("engine reset longer than one cycle");
    chk_ready_drop: assert property (engineReset |=> !chipReady && !convEnable)
        else $error("ready not dropped after full reset");
    chk_drop_cause: assert property ($fell(chipReady) |-> engineReset)
        else $error("ready dropped without full reset");
    chk_ready_span: assert property ($rose(chipReady) |-> lowCnt_q inside {[READY_CYCLES-1:READY_CYCLES+1]})
        else $error("ready delay length wrong");
    chk_no_conv_unready: assert property (!chipReady |-> !convEnable)
        else $error("conversions allowed while not ready");
    chk_watchdog_halt: assert property (fault.fsmWatchdog |=> !convEnable [*8])
        else $error("conversions not halted by watchdog");
    chk_resume_ready: assert property ($rose(convEnable) |-> chipReady)
        else $error("conversions resumed while not ready");
    chk_sda_change_low: assert property (($fell(sdaOeN) || $rose(sdaOeN)) |-> !sclIn)
        else $error("data line changed while clock high");
    cover property (engineReset);
    cover property (fault.fsmWatchdog);
    cover property ($rose(chipReady));
    cover property ($fell(sdaOeN));
endmodule
bind tsr_regs tsr_regs_chk #(.READY_CYCLES(READY_CYCLES)) u_chk (.clk(clk), .reset(reset),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .scan(scan), .fault(fault),
    .convEnable(convEnable), .engineReset(engineReset), .chipReady(chipReady));
`default_nettype wire

/* File: tsr_host.sv */
// two-wire bus controller model standing in for the host
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
    // clock
    input wire logic clk,
    // device pins
    input wire logic sdaOut,
    input wire logic sdaOeN,
    output logic sclIn,
    output logic sdaIn
);
    import tsr_pkg::*;
    logic hostSda = 1'b1;
    logic [7:0] rdBuf [0:15];
    int ackMiss = 0;
    initial sclIn = 1'b1;
    // open drain line with pull-up: low if either side pulls
    assign sdaIn = hostSda & (sdaOeN | sdaOut);
    // slow bus: each quarter bit is 8 clocks, well above the synchroniser lag
    task automatic waitq();
        repeat (8) @(negedge clk);
    endtask
    task automatic bitx(input logic b, output logic r);
        waitq();
        hostSda = b;
        waitq();
        sclIn = 1'b1;
        waitq();
        r = sdaIn;
        waitq();
        sclIn = 1'b0;
    endtask
    task automatic start();
        hostSda = 1'b1;
        waitq();
        sclIn = 1'b1;
        waitq();
        hostSda = 1'b0;
        waitq();
        sclIn = 1'b0;
    endtask
    task automatic stop();
        waitq();
        hostSda = 1'b0;
        waitq();
        sclIn = 1'b1;
        waitq();
        hostSda = 1'b1;
        waitq();
    endtask
    task automatic sendByte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        if (r !== 1'b0) ackMiss++;
    endtask
    task automatic readByte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, r);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        start();
        sendByte({TARGET_ADDR, 1'b0});
        sendByte(ptr);
        sendByte(data);
        stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        start();
        sendByte({TARGET_ADDR, 1'b0});
        sendByte(ptr);
        start();
        sendByte({TARGET_ADDR, 1'b1});
        for (int i = 0; i < n; i++) readByte(i == n - 1, rdBuf[i]);
        stop();
    endtask
endmodule
`default_nettype wire

/* File: test_tsr_regs.sv */
// self-checking bench for the touch status register bank
`timescale 1ns/1ps
`default_nettype none
module test_tsr_regs;
    import tsr_pkg::*;
    localparam int RDY = 2000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    tsr_scan_t scan = '0;
    tsr_fault_t fault = '0;
    logic sclIn, sdaIn, sdaOut, sdaOeN, convEnable, engineReset, chipReady;
    logic [7:0] expQ [0:11];
    int n_fail = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    tsr_regs #(.CHANNELS(4), .TIMEOUT_CYCLES(50), .READY_CYCLES(RDY)) dut (.clk(clk),
        .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .scan(scan), .fault(fault), .convEnable(convEnable), .engineReset(engineReset),
        .chipReady(chipReady));
    tsr_host host (.clk(clk), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclIn(sclIn), .sdaIn(sdaIn));
    task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpBit(input logic got, input logic exp);
        cmpByte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic chkRd(input logic [7:0] ptr, input int n);
        host.rd(ptr, n);
        for (int i = 0; i < n; i++) cmpByte(host.rdBuf[i], expQ[i]);
    endtask
    task automatic pulse(input logic [3:0] p, input logic [47:0] r, input tsr_fault_t f);
        @(negedge clk);
        scan.press = p;
        scan.result = r;
        scan.sampleValid = 1'b1;
        fault = f;
        @(negedge clk);
        scan.sampleValid = 1'b0;
        fault = '0;
    endtask
    task automatic summarize();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        expQ = '{0: 8'h60, default: 8'h00};
        chkRd(OFS_STATUS, 12);
        cmpBit(convEnable, 1'b1);
        // ch3 ch2 ch1 ch0 packed; two full-scale codes on purpose
        pulse(4'h5, {12'hABC, 12'h800, 12'h123, 12'h7FF}, '{1'b0, 1'b1, 1'b1});
        expQ = '{8'hF7, 8'h05, 8'hFF, 8'h07, 8'h23, 8'h01, 8'h00, 8'h08, 8'hBC, 8'h0A, 0, 0};
        chkRd(OFS_STATUS, 10);
        pulse(4'h0, 48'h0, '0);
        // press stayed live after the first read, so bit 7 is set once more
        expQ = '{0: 8'hE0, default: 8'h00};
        chkRd(OFS_STATUS, 2);
        pulse(4'h0, 48'h0, '{1'b1, 1'b0, 1'b0});
        cmpBit(convEnable, 1'b0);
        expQ[0] = 8'h68;
        chkRd(OFS_STATUS, 1);
        host.wr(OFS_RESET, 8'h10);
        cmpBit(chipReady, 1'b0);
        cmpBit(convEnable, 1'b0);
        host.wr(OFS_RESET, 8'h01);
        for (int i = 0; i < RDY + 50 && chipReady !== 1'b1; i++) @(negedge clk);
        cmpBit(chipReady, 1'b1);
        cmpBit(convEnable, 1'b1);
        expQ = '{0: 8'h60, default: 8'h00};
        chkRd(OFS_STATUS, 12);
        // hold set before configuration, cleared after
        host.wr(OFS_RESET, 8'h01);
        cmpBit(convEnable, 1'b0);
        pulse(4'h3, {36'h0, 12'h321}, '0);
        chkRd(OFS_STATUS, 4);
        expQ[0] = 8'h01;
        chkRd(OFS_RESET, 1);
        host.wr(OFS_RESET, 8'h00);
        cmpBit(convEnable, 1'b1);
        pulse(4'h2, {24'h0, 12'h456, 12'h000}, '0);
        host.wr(OFS_PRESS, 8'hFF);
        expQ = '{8'hE2, 8'h02, 8'h00, 8'h00, 8'h56, 8'h04, 0, 0, 0, 0, 0, 0};
        chkRd(OFS_STATUS, 6);
        cmpByte(8'(host.ackMiss), 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
